// ===== hdl/port_switch_protection_ctrl.v
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "port_switch_regs.vh"

module port_switch_protection_ctrl #(
    parameter TW = 16
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire [3:0]    addr,
    input  wire [15:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [15:0]   rdata,
    input  wire [2:0]    current_limit_setting,
    input  wire          port_power_enable,
    input  wire          emulation_enable,
    input  wire          mode_select_one,
    input  wire          mode_select_two,
    input  wire [1:0]    power_state,
    input  wire          dcp_accepted,
    input  wire          emul_timeout_active,
    input  wire          profile_apply_req,
    input  wire          removal_detect,
    input  wire          source_undervoltage,
    input  wire          error_recovery,
    input  wire          over_limit,
    input  wire          vbus_below_min,
    input  wire          vbus_below_test,
    input  wire          temp_over_reg,
    input  wire          temp_below_reg_hyst,
    input  wire          temp_over_shutdown,
    input  wire          temp_below_shutdown_hyst,
    output reg           switch_close,
    output reg           bypass_cap_sel,
    output reg           constant_current_mode,
    output reg  [2:0]    active_limit,
    output reg           cc_low_current_bound,
    output reg           discharge_on,
    output reg           profile_remove,
    output reg           error_req,
    output wire          fault_alert_n_oe
);

    // ************************************************************
    // Registers
    // ************************************************************
    reg [2:0]    hw_limit_q;
    reg          hw_latched_q;
    reg [2:0]    prog_limit_q;
    reg [TW-1:0] retry_time_q;
    reg [TW-1:0] restore_time_q;
    reg [TW-1:0] disch_time_q;
    reg [TW-1:0] mask_time_q;
    reg [TW-1:0] blank_time_q;
    reg          disch_err_q;
    reg          trip_err_q;
    reg          alert_q;
    reg          tsd_q;
    reg          treg_q;
    reg          forced_q;
    reg          restoring_q;
    reg          waiting_q;
    reg [TW-1:0] tmr_q;
    reg [TW-1:0] disch_cnt_q;
    reg [TW-1:0] mask_cnt_q;
    reg [TW-1:0] blank_cnt_q;
    reg          blank_done_q;
    reg          ppe_q;
    reg [1:0]    ps_q;
    reg [2:0]    ctl_q;
    reg          emu_block_q;
    reg [2:0]    lim_q;

    wire [1:0] mode = {mode_select_two, mode_select_one};
    wire [2:0] ctl_now = {emulation_enable, mode_select_two,
                          mode_select_one};
    wire in_active = (power_state == `PS_ACTIVE);
    wire bus_disch = wr && (addr == `ADDR_CTRL) &&
                     wdata[`CTRL_DISCH_CMD] && in_active;
    wire err_clear = wr && (addr == `ADDR_CTRL) && wdata[`CTRL_ERR_CLEAR];

    // Hand-over between bypass path and port switch in either direction.
    wire handover = ((ps_q == `PS_DETECT) && in_active) ||
                    ((ps_q == `PS_ACTIVE) &&
                     (power_state == `PS_DETECT));
    wire sleep_cmd = (power_state == `PS_SLEEP) && (ps_q != `PS_SLEEP);
    wire disch_start = (ppe_q && !port_power_enable) || removal_detect ||
                       source_undervoltage || sleep_cmd ||
                       profile_apply_req || error_recovery || bus_disch ||
                       handover;

    // Scheme selection from the active mode before thermal overrides.
    reg base_cc;
    always @*
    begin
        case (mode)
            `AM_CDP:       base_cc = 1'b1;
            `AM_DCE:       base_cc = emul_timeout_active ||
                                     (dcp_accepted && over_limit &&
                                      prog_limit_q <= `LIM_1A5);
            `AM_DEDICATED: base_cc = dcp_accepted && over_limit &&
                                     (prog_limit_q <= `LIM_1A5);
            default:       base_cc = 1'b0;
        endcase
    end

    wire cc_eff = base_cc && !forced_q;
    wire trip_event = switch_close && !cc_eff && over_limit;
    wire cc_open = cc_eff && (vbus_below_min || temp_over_shutdown);
    wire [2:0] lim_one_below = (prog_limit_q == `LIM_MIN) ? `LIM_MIN :
                               prog_limit_q - 3'h1;

    // ************************************************************
    // Hardware limit capture and register writes
    // ************************************************************
    // The strap is caught after reset release, never by the reset itself.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hw_limit_q     <= 3'h7;
            hw_latched_q   <= 1'b0;
            prog_limit_q   <= 3'h7;
            retry_time_q   <= `RST_RETRY;
            restore_time_q <= `RST_RESTORE;
            disch_time_q   <= `RST_DISCH;
            mask_time_q    <= `RST_MASK;
            blank_time_q   <= `RST_BLANK;
        end
        else
        begin
            if (!hw_latched_q)
            begin
                hw_limit_q   <= current_limit_setting;
                prog_limit_q <= current_limit_setting;
                hw_latched_q <= 1'b1;
            end
            else if (wr && addr == `ADDR_LIMIT)
                prog_limit_q <= (wdata[2:0] > hw_limit_q) ? hw_limit_q :
                                wdata[2:0];
            if (wr && addr == `ADDR_RETRY_TIME)
                retry_time_q <= wdata[TW-1:0];
            if (wr && addr == `ADDR_RESTORE_TIME)
                restore_time_q <= wdata[TW-1:0];
            if (wr && addr == `ADDR_DISCH_TIME)
                disch_time_q <= wdata[TW-1:0];
            if (wr && addr == `ADDR_MASK_TIME)
                mask_time_q <= wdata[TW-1:0];
            if (wr && addr == `ADDR_BLANK_TIME)
                blank_time_q <= wdata[TW-1:0];
        end
    end

    // ************************************************************
    // Dynamic thermal management and shutdown
    // ************************************************************
    // Waiting means the switch is open for a retry interval.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tsd_q       <= 1'b0;
            treg_q      <= 1'b0;
            forced_q    <= 1'b0;
            restoring_q <= 1'b0;
            waiting_q   <= 1'b0;
            tmr_q       <= {TW{1'b0}};
            lim_q       <= 3'h7;
            emu_block_q <= 1'b0;
            ctl_q       <= 3'h0;
        end
        else
        begin
            ctl_q <= ctl_now;
            if (temp_over_shutdown)
                tsd_q <= 1'b1;
            else if (temp_below_shutdown_hyst)
                tsd_q <= 1'b0;
            if (ctl_q != ctl_now)
                emu_block_q <= 1'b0;
            if (temp_over_reg && dcp_accepted)
                emu_block_q <= 1'b1;
            if (!treg_q && !restoring_q)
                lim_q <= prog_limit_q;
            if (waiting_q)
            begin
                if (tmr_q >= retry_time_q)
                begin
                    waiting_q <= 1'b0;
                    tmr_q     <= {TW{1'b0}};
                end
                else
                    tmr_q <= tmr_q + 1'b1;
            end
            else if (temp_over_reg)
            begin
                treg_q      <= 1'b1;
                restoring_q <= 1'b0;
                tmr_q       <= {TW{1'b0}};
                if (lim_q != `LIM_MIN)
                begin
                    lim_q     <= lim_q - 3'h1;
                    waiting_q <= 1'b1;
                end
                else if (base_cc && !forced_q)
                begin
                    forced_q  <= 1'b1;
                    lim_q     <= lim_one_below;
                    waiting_q <= 1'b1;
                end
                // Trip at minimum: stay closed at minimum limit.
            end
            else if (treg_q && temp_below_reg_hyst)
            begin
                treg_q <= 1'b0;
                if (forced_q)
                begin
                    restoring_q <= 1'b1;
                    tmr_q       <= {TW{1'b0}};
                end
                else
                    lim_q <= prog_limit_q;
            end
            else if (restoring_q)
            begin
                if (tmr_q >= restore_time_q)
                begin
                    restoring_q <= 1'b0;
                    forced_q    <= 1'b0;
                    lim_q       <= prog_limit_q;
                    tmr_q       <= {TW{1'b0}};
                end
                else
                    tmr_q <= tmr_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // VBUS discharge sequencing and error flags
    // ************************************************************
    // Thermal events are deliberately absent from the discharge start.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            discharge_on <= 1'b0;
            disch_cnt_q  <= {TW{1'b0}};
            disch_err_q  <= 1'b0;
            trip_err_q   <= 1'b0;
            ppe_q        <= 1'b0;
            ps_q         <= `PS_SLEEP;
            error_req    <= 1'b0;
        end
        else
        begin
            ppe_q     <= port_power_enable;
            ps_q      <= power_state;
            error_req <= 1'b0;
            if (disch_start)
            begin
                discharge_on <= 1'b1;
                disch_cnt_q  <= {TW{1'b0}};
            end
            else if (discharge_on)
            begin
                if (disch_cnt_q >= disch_time_q)
                begin
                    discharge_on <= 1'b0;
                    if (!vbus_below_test)
                        error_req <= 1'b1;
                end
                else
                    disch_cnt_q <= disch_cnt_q + 1'b1;
            end
            // A new event wins over a software clear in the same cycle.
            if (discharge_on && !disch_start &&
                disch_cnt_q >= disch_time_q && !vbus_below_test)
                disch_err_q <= 1'b1;
            else if (err_clear)
                disch_err_q <= 1'b0;
            if (trip_event)
            begin
                trip_err_q <= 1'b1;
                error_req  <= 1'b1;
            end
            else if (err_clear)
                trip_err_q <= 1'b0;
        end
    end

    // ************************************************************
    // Alert masking and power-up blanking
    // ************************************************************
    wire err_level = trip_err_q || disch_err_q;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blank_cnt_q  <= {TW{1'b0}};
            blank_done_q <= 1'b0;
            mask_cnt_q   <= {TW{1'b0}};
            alert_q      <= 1'b0;
        end
        else
        begin
            if (!blank_done_q)
            begin
                if (blank_cnt_q >= blank_time_q)
                    blank_done_q <= 1'b1;
                else
                    blank_cnt_q <= blank_cnt_q + 1'b1;
            end
            if (!err_level)
                mask_cnt_q <= {TW{1'b0}};
            else if (mask_cnt_q <= mask_time_q)
                mask_cnt_q <= mask_cnt_q + 1'b1;
            alert_q <= blank_done_q &&
                       ((err_level && mask_cnt_q > mask_time_q) ||
                        tsd_q);
        end
    end
    assign fault_alert_n_oe = alert_q;

    // ************************************************************
    // Switch and limit outputs
    // ************************************************************
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            switch_close          <= 1'b0;
            bypass_cap_sel        <= 1'b0;
            constant_current_mode <= 1'b0;
            active_limit          <= `LIM_MIN;
            cc_low_current_bound  <= `BOUND_NORMAL;
            profile_remove        <= 1'b0;
        end
        else
        begin
            switch_close <= in_active && port_power_enable && !tsd_q &&
                            !temp_over_shutdown && !discharge_on &&
                            !waiting_q && !trip_event && !cc_open &&
                            !trip_err_q;
            bypass_cap_sel <= (power_state == `PS_DETECT);
            constant_current_mode <= cc_eff;
            active_limit <= lim_q;
            cc_low_current_bound <= forced_q ? `BOUND_100MA :
                                    `BOUND_NORMAL;
            profile_remove <= emu_block_q;
        end
    end

    // ************************************************************
    // Register read port
    // ************************************************************
    reg [15:0] rd_d;
    always @*
    begin
        rd_d = 16'h0000;
        case (addr)
            `ADDR_LIMIT:
                rd_d = {9'h000, hw_limit_q, 1'b0, prog_limit_q};
            `ADDR_STATUS:
                rd_d = {8'h00, switch_close, discharge_on, forced_q,
                        constant_current_mode, tsd_q, treg_q,
                        trip_err_q, disch_err_q};
            `ADDR_RETRY_TIME:   rd_d[TW-1:0] = retry_time_q;
            `ADDR_RESTORE_TIME: rd_d[TW-1:0] = restore_time_q;
            `ADDR_DISCH_TIME:   rd_d[TW-1:0] = disch_time_q;
            `ADDR_MASK_TIME:    rd_d[TW-1:0] = mask_time_q;
            `ADDR_BLANK_TIME:   rd_d[TW-1:0] = blank_time_q;
            default:            rd_d = 16'h0000;
        endcase
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 16'h0000;
        else
            rdata <= rd ? rd_d : 16'h0000;
    end

endmodule // port_switch_protection_ctrl

// ===== shared/port_switch_regs.vh
`ifndef PORT_SWITCH_REGS_VH
`define PORT_SWITCH_REGS_VH

// ****************************************************************
// Address map of the plain register port
// ****************************************************************
`define ADDR_CTRL        4'h0
`define ADDR_LIMIT       4'h1
`define ADDR_STATUS      4'h2
`define ADDR_RETRY_TIME  4'h3
`define ADDR_RESTORE_TIME 4'h4
`define ADDR_DISCH_TIME  4'h5
`define ADDR_MASK_TIME   4'h6
`define ADDR_BLANK_TIME  4'h7

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_DISCH_CMD   0
`define CTRL_ERR_CLEAR   1

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_DISCH_ERR     0
`define ST_TRIP_ERR      1
`define ST_TREG          2
`define ST_TSD           3
`define ST_CC_MODE       4
`define ST_FORCED_TRIP   5
`define ST_DISCHARGING   6
`define ST_SWITCH_ON     7

// ****************************************************************
// Power states
// ****************************************************************
`define PS_SLEEP         2'h0
`define PS_DETECT        2'h1
`define PS_ACTIVE        2'h2
`define PS_ERROR         2'h3

// ****************************************************************
// Active modes
// ****************************************************************
`define AM_PASS          2'h0
`define AM_CDP           2'h1
`define AM_DCE           2'h2
`define AM_DEDICATED     2'h3

// ****************************************************************
// Limit codes and reset values
// ****************************************************************
`define LIM_MIN          3'h0
`define LIM_1A5          3'h4
`define BOUND_NORMAL     1'b0
`define BOUND_100MA      1'b1
`define RST_RETRY        16'h0FA0
`define RST_RESTORE      16'h0FA0
`define RST_DISCH        16'h0FA0
`define RST_MASK         16'h0FA0
`define RST_BLANK        16'h0FA0

`endif

// ===== tb/port_load_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Portable load on the port
// ****************************************************************
module port_load_model (
    input  wire clk,
    input  wire rstn,
    input  wire switch_close,
    input  wire discharge_on,
    input  wire heavy,
    input  wire sag,
    input  wire stuck,
    output wire over_limit,
    output wire vbus_below_min,
    output wire vbus_below_test
);
    reg vbus_q;

    // The rail stays up after release; only a working discharge drains
    // it, so a stuck rail models a failed discharge path.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            vbus_q <= 1'b0;
        else if (switch_close)
            vbus_q <= 1'b1;
        else if (discharge_on && !stuck)
            vbus_q <= 1'b0;
    end

    // Over-limit and below-minimum flags follow the switch state in the same domain; the test flag follows the rail.
    assign over_limit = switch_close & heavy;
    assign vbus_below_min = switch_close & sag;
    assign vbus_below_test = !vbus_q;
endmodule // port_load_model

// ===== tb/port_switch_checker_properties.sv
`timescale 1ns/10ps
`include "port_switch_regs.vh"

// ****************************************************************
// Protection checker
// ****************************************************************
module port_switch_checker (
    input wire       clk,
    input wire       rstn,
    input wire       port_power_enable,
    input wire [1:0] power_state,
    input wire       profile_apply_req,
    input wire       removal_detect,
    input wire       error_recovery,
    input wire       over_limit,
    input wire       vbus_below_min,
    input wire       temp_over_shutdown,
    input wire       switch_close,
    input wire       bypass_cap_sel,
    input wire       constant_current_mode,
    input wire       discharge_on,
    input wire       error_req,
    input wire       fault_alert_n_oe
);
    localparam int BLANK = 4000;
    reg [12:0] up_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Cycles since reset release, saturating so it never wraps.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            up_q <= 13'h0000;
        else if (up_q < BLANK)
            up_q <= up_q + 13'h0001;
    end

    trip_error_a: assert property (switch_close && !constant_current_mode
        && over_limit |=> error_req) else $error("trip gave no error");
    shutdown_off_a: assert property (temp_over_shutdown |=>
        !switch_close) else $error("switch on above shutdown");
    cc_low_vbus_a: assert property (constant_current_mode &&
        vbus_below_min |=> !switch_close) else $error("cc kept switch on");
    detect_cap_a: assert property (power_state == `PS_DETECT |=>
        bypass_cap_sel) else $error("detect without bypass cap");
    enable_disch_a: assert property ($fell(port_power_enable) |=>
        discharge_on) else $error("no discharge on disable");
    removal_disch_a: assert property (removal_detect |=>
        discharge_on) else $error("no discharge on removal");
    profile_disch_a: assert property (profile_apply_req |=>
        discharge_on) else $error("no discharge before profile");
    recover_disch_a: assert property (error_recovery |=>
        discharge_on) else $error("no discharge on recovery");
    alert_blank_a: assert property (up_q < BLANK |->
        !fault_alert_n_oe) else $error("alert during blanking");

    trip_c: cover property (error_req && !discharge_on);
    disch_c: cover property ($rose(discharge_on));
    shutdown_c: cover property (temp_over_shutdown && !switch_close);
endmodule // port_switch_checker

bind port_switch_protection_ctrl port_switch_checker chk_inst (
    .clk(clk), .rstn(rstn), .port_power_enable(port_power_enable),
    .power_state(power_state), .profile_apply_req(profile_apply_req),
    .removal_detect(removal_detect), .error_recovery(error_recovery),
    .over_limit(over_limit), .vbus_below_min(vbus_below_min),
    .temp_over_shutdown(temp_over_shutdown), .switch_close(switch_close),
    .bypass_cap_sel(bypass_cap_sel), .discharge_on(discharge_on),
    .constant_current_mode(constant_current_mode),
    .error_req(error_req), .fault_alert_n_oe(fault_alert_n_oe)
);

// ===== tb/port_switch_protection_ctrl_tb.sv
`timescale 1ns/10ps

// ****************************************************************
// Bench top
// ****************************************************************
module port_switch_protection_ctrl_tb;
    reg clk = 0, rstn = 0, wr = 0, rd = 0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg [15:0] rv;
    reg [2:0] current_limit_setting = 3'h5;
    reg [1:0] power_state = 2'h0;
    reg port_power_enable = 0, mode_select_one = 0, heavy = 0;
    reg sag = 0, stuck = 0, profile_apply_req = 0, removal_detect = 0;
    reg source_undervoltage = 0, error_recovery = 0, temp_over_reg = 0;
    reg temp_below_reg_hyst = 0, temp_over_shutdown = 0;
    reg temp_below_shutdown_hyst = 0;
    reg mode_select_two = 0, dcp_accepted = 0;
    wire [15:0] rdata;
    wire [2:0] active_limit;
    wire over_limit, vbus_below_min, vbus_below_test, switch_close;
    wire bypass_cap_sel, constant_current_mode, discharge_on, error_req;
    wire fault_alert_n_oe;
    wire cc_low_current_bound, profile_remove;
    integer fails = 0, checks_done = 0, n, i;

    port_switch_protection_ctrl port_switch_protection_ctrl_inst (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .current_limit_setting(current_limit_setting),
        .port_power_enable(port_power_enable), .emulation_enable(1'b0),
        .mode_select_one(mode_select_one),
        .mode_select_two(mode_select_two),
        .power_state(power_state), .dcp_accepted(dcp_accepted),
        .emul_timeout_active(1'b0), .profile_apply_req(profile_apply_req),
        .removal_detect(removal_detect), .error_recovery(error_recovery),
        .source_undervoltage(source_undervoltage), .over_limit(over_limit),
        .vbus_below_min(vbus_below_min), .vbus_below_test(vbus_below_test),
        .temp_over_reg(temp_over_reg),
        .temp_below_reg_hyst(temp_below_reg_hyst),
        .temp_over_shutdown(temp_over_shutdown),
        .temp_below_shutdown_hyst(temp_below_shutdown_hyst),
        .switch_close(switch_close), .bypass_cap_sel(bypass_cap_sel),
        .constant_current_mode(constant_current_mode),
        .active_limit(active_limit),
        .cc_low_current_bound(cc_low_current_bound),
        .discharge_on(discharge_on), .profile_remove(profile_remove),
        .error_req(error_req), .fault_alert_n_oe(fault_alert_n_oe)
    );

    port_load_model port_load_model_inst (
        .clk(clk), .rstn(rstn), .switch_close(switch_close),
        .discharge_on(discharge_on), .heavy(heavy), .sag(sag),
        .stuck(stuck), .over_limit(over_limit),
        .vbus_below_min(vbus_below_min), .vbus_below_test(vbus_below_test)
    );

    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;

    // The tick and read tasks land just past an edge so outputs are settled when sampled.
    task tick(input integer c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task wr_reg(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task rd_reg(input [3:0] a, output [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 d = rdata;
    endtask
    task chk_reg(input [15:0] got, input [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_bit(input got, input exp);
        chk_reg({15'h0000, got}, {15'h0000, exp});
    endtask
    task wait_on;
        for (n = 0; n < 300 && switch_close !== 1; n = n + 1)
            tick(1);
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // A hang is cut off well past the expected run length.
    initial
    begin
        #2000000;
        fails = fails + 1;
        wrap_up;
    end

    // Main sequence; short retry, restore, discharge and mask timers keep waits small, but blanking stays at 4000 cycles.
    initial
    begin
        tick(20);
        rstn <= 1;
        tick(2);
        for (i = 3; i < 7; i = i + 1)
            wr_reg(i[3:0], 16'h0004);
        wr_reg(4'h1, 16'h0007);
        rd_reg(4'h1, rv);
        chk_reg(rv, 16'h0055);
        wr_reg(4'h1, 16'h0003);
        rd_reg(4'h1, rv);
        chk_reg(rv, 16'h0053);
        rd_reg(4'h8, rv);
        chk_reg(rv, 16'h0000);
        power_state <= 2'h2;
        port_power_enable <= 1;
        wait_on;
        chk_bit(switch_close, 1);
        chk_bit(constant_current_mode, 0);
        temp_over_reg <= 1;
        tick(1);
        temp_over_reg <= 0;
        tick(1);
        chk_reg({13'h0000, active_limit}, 16'h0002);
        chk_bit(switch_close, 0);
        chk_bit(discharge_on, 0);
        tick(10);
        chk_bit(switch_close, 1);
        temp_below_reg_hyst <= 1;
        tick(1);
        temp_below_reg_hyst <= 0;
        tick(1);
        chk_reg({13'h0000, active_limit}, 16'h0003);
        temp_over_shutdown <= 1;
        tick(2);
        chk_bit(switch_close, 0);
        temp_over_shutdown <= 0;
        tick(5);
        chk_bit(switch_close, 0);
        temp_below_shutdown_hyst <= 1;
        tick(1);
        temp_below_shutdown_hyst <= 0;
        wait_on;
        chk_bit(switch_close, 1);
        heavy <= 1;
        for (n = 0; n < 20 && error_req !== 1; n = n + 1)
            tick(1);
        chk_bit(error_req, 1);
        heavy <= 0;
        rd_reg(4'h2, rv);
        chk_bit(rv[1], 1);
        chk_bit(switch_close, 0);
        wr_reg(4'h0, 16'h0002);
        for (i = 0; i < 4; i = i + 1)
        begin
            {profile_apply_req, removal_detect, source_undervoltage,
                error_recovery} <= 4'h1 << i;
            tick(1);
            {profile_apply_req, removal_detect, source_undervoltage,
                error_recovery} <= 4'h0;
            tick(1);
            chk_bit(discharge_on, 1);
            tick(8);
        end
        wait_on;
        wr_reg(4'h0, 16'h0001);
        tick(1);
        for (n = 1; n < 50 && discharge_on === 1; n = n + 1)
            tick(1);
        chk_reg(n[15:0], 16'h0005);
        wait_on;
        power_state <= 2'h1;
        for (n = 0; n < 5 && discharge_on !== 1; n = n + 1)
            tick(1);
        chk_bit(discharge_on, 1);
        chk_bit(bypass_cap_sel, 1);
        tick(10);
        power_state <= 2'h2;
        wait_on;
        mode_select_one <= 1;
        tick(3);
        chk_bit(constant_current_mode, 1);
        sag <= 1;
        tick(1);
        chk_bit(switch_close, 0);
        sag <= 0;
        wait_on;
        // Held heat walks the limit ladder down to the floor twice.
        temp_over_reg <= 1;
        tick(40);
        chk_bit(cc_low_current_bound, 1);
        chk_bit(constant_current_mode, 0);
        chk_bit(switch_close, 1);
        chk_reg({13'h0000, active_limit}, 16'h0000);
        {temp_over_reg, temp_below_reg_hyst} <= 2'h1;
        tick(1);
        temp_below_reg_hyst <= 0;
        tick(2);
        chk_bit(cc_low_current_bound, 1);
        tick(8);
        chk_bit(constant_current_mode, 1);
        chk_reg({13'h0000, active_limit}, 16'h0003);
        mode_select_one <= 0;
        wait_on;
        stuck <= 1;
        port_power_enable <= 0;
        for (n = 0; n < 50 && error_req !== 1; n = n + 1)
            tick(1);
        chk_bit(error_req, 1);
        rd_reg(4'h2, rv);
        chk_bit(rv[0], 1);
        stuck <= 0;
        tick(10);
        chk_bit(fault_alert_n_oe, 0);
        tick(4000);
        chk_bit(fault_alert_n_oe, 1);
        wr_reg(4'h0, 16'h0002);
        tick(2);
        chk_bit(fault_alert_n_oe, 0);
        dcp_accepted <= 1;
        temp_over_reg <= 1;
        tick(2);
        chk_bit(profile_remove, 1);
        temp_over_reg <= 0;
        dcp_accepted <= 0;
        mode_select_two <= 1;
        tick(3);
        chk_bit(profile_remove, 0);
        chk_bit(constant_current_mode, 0);
        wrap_up;
    end
endmodule // port_switch_protection_ctrl_tb
